/* File: mps_regs.svh */
`ifndef MPS_REGS_SVH
`define MPS_REGS_SVH
// ************************************
// Timing
// ************************************
`define MPS_CLK_NS          100
`define MPS_RET_WAKE_NS     200
`define MPS_OFF_WAKE_NS     1000
`define MPS_RET_WAKE_CYC    ((`MPS_RET_WAKE_NS + `MPS_CLK_NS - 1) / `MPS_CLK_NS)
`define MPS_OFF_WAKE_CYC    ((`MPS_OFF_WAKE_NS + `MPS_CLK_NS - 1) / `MPS_CLK_NS)
// ************************************
// Register offsets
// ************************************
`define MPS_CORE_EN_OFS     8'h00
`define MPS_CORE_RET_OFS    8'h04
`define MPS_SRAM_EN_OFS     8'h08
`define MPS_SRAM_RET_OFS    8'h0C
`define MPS_IO_EN_OFS       8'h10
`define MPS_IO_ACT_OFS      8'h14
`define MPS_IO_AUTO_OFS     8'h18
`define MPS_HYST_OFS        8'h1C
`define MPS_MEM_STATE_OFS   8'h20
`define MPS_IO_STATE_OFS    8'h24
// ************************************
// Fields and reset values
// ************************************
`define MPS_AUTO_OFF_LSB    0
`define MPS_AUTO_ON_LSB     16
`define MPS_EN_RST          32'hFFFF_FFFF
`define MPS_RET_RST         32'h0000_0000
`define MPS_HYST_RST        16'h0040
`endif

/* File: mps_pkg.sv */
package mps_pkg;
	typedef enum logic [1:0] {
		MPS_MEM_ACTIVE = 2'h0,
		MPS_MEM_RET    = 2'h1,
		MPS_MEM_WAKE   = 2'h3,
		MPS_MEM_OFF    = 2'h2
	} mps_mem_state_e;
	typedef enum logic [1:0] {
		MPS_IO_OFF    = 2'h0,
		MPS_IO_SLEEP  = 2'h1,
		MPS_IO_ACTIVE = 2'h3
	} mps_io_state_e;
	typedef logic [15:0] mps_hyst_t;
endpackage : mps_pkg

/* File: mps_io_if.sv */
`timescale 1ns/10ps
interface mps_io_if #(parameter int N_IO = 4);
	import mps_pkg::*;
	logic [N_IO-1:0] dev_en;
	logic [N_IO-1:0] en_set;
	logic [N_IO-1:0] if_act;
	logic [N_IO-1:0] auto_off;
	logic [N_IO-1:0] auto_on;
	logic [N_IO-1:0] idle_req;
	logic [N_IO-1:0] wake_req;
	mps_io_state_e   state [N_IO];
	modport ctrl (output dev_en, en_set, if_act, auto_off, auto_on, idle_req, wake_req, input state);
	modport unit (input dev_en, en_set, if_act, auto_off, auto_on, idle_req, wake_req, output state);
endinterface : mps_io_if

/* File: mps_mem_unit.sv */
`timescale 1ns/10ps
`include "mps_regs.svh"
module mps_mem_unit #(
	parameter int WAKE_W = 4
) (
	input  logic                sys_clk,
	input  logic                srst,
	input  logic                deep_sleep,
	input  logic                pend,
	input  logic                pwr_en,
	input  logic                ret_en,
	input  mps_pkg::mps_hyst_t  hyst_load,
	output mps_pkg::mps_mem_state_e state,
	output logic                grant
);
	import mps_pkg::*;
	mps_hyst_t      hyst_r;
	logic [WAKE_W-1:0] wake_r;
	mps_mem_state_e state_r;
	logic           hold;

	assign hold  = !deep_sleep || pend;
	assign state = state_r;
	assign grant = pend && (state_r == MPS_MEM_ACTIVE);

	always_ff @(posedge sys_clk) begin
		if (srst)
			hyst_r <= '0;
		else if (hold || state_r != MPS_MEM_ACTIVE)
			hyst_r <= hyst_load;
		else if (hyst_r != '0)
			hyst_r <= hyst_r - 16'h0001;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_r <= MPS_MEM_ACTIVE;
			wake_r  <= '0;
		end else begin
			case (state_r)
				MPS_MEM_ACTIVE: if (!hold && hyst_r == '0) begin
					state_r <= (pwr_en && ret_en) ? MPS_MEM_RET : MPS_MEM_OFF;
				end
				MPS_MEM_RET: if (hold) begin
					state_r <= MPS_MEM_WAKE;
					wake_r  <= WAKE_W'(`MPS_RET_WAKE_CYC - 1);
				end
				MPS_MEM_OFF: if (hold) begin
					state_r <= MPS_MEM_WAKE;
					wake_r  <= WAKE_W'(`MPS_OFF_WAKE_CYC - 1);
				end
				MPS_MEM_WAKE: if (wake_r == '0) begin
					state_r <= MPS_MEM_ACTIVE;
				end else begin
					wake_r <= wake_r - 1'b1;
				end
				default: state_r <= MPS_MEM_ACTIVE;
			endcase
		end
	end

	hyst_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
		(state_r == MPS_MEM_ACTIVE && hyst_r != '0) |=> state_r == MPS_MEM_ACTIVE)
		else $error("memory left active before hysteresis expired");
endmodule : mps_mem_unit

/* File: mps_io_unit.sv */
`timescale 1ns/10ps
module mps_io_unit #(
	parameter int N_IO = 4
) (
	input  logic       sys_clk,
	input  logic       srst,
	mps_io_if.unit     io
);
	import mps_pkg::*;
	mps_io_state_e state_r [N_IO];

	for (genvar i = 0; i < N_IO; i++) begin : g_io
		assign io.state[i] = state_r[i];
		always_ff @(posedge sys_clk) begin
			if (srst)
				state_r[i] <= MPS_IO_OFF;
			else begin
				case (state_r[i])
					MPS_IO_OFF: if (io.dev_en[i] && (io.en_set[i] || (io.auto_on[i] && io.wake_req[i]))) begin
						state_r[i] <= MPS_IO_SLEEP;
					end
					MPS_IO_SLEEP: if (!io.dev_en[i]) begin
						state_r[i] <= MPS_IO_OFF;
					end else if (io.if_act[i]) begin
						state_r[i] <= MPS_IO_ACTIVE;
					end else if (io.auto_off[i] && io.idle_req[i]) begin
						state_r[i] <= MPS_IO_OFF;
					end
					MPS_IO_ACTIVE: if (!io.dev_en[i]) begin
						state_r[i] <= MPS_IO_OFF;
					end else if (!io.if_act[i]) begin
						state_r[i] <= MPS_IO_SLEEP;
					end
					default: state_r[i] <= MPS_IO_OFF;
				endcase
			end
		end
		dev_off_a: assert property (@(posedge sys_clk) disable iff (srst)
			!io.dev_en[i] |=> state_r[i] == MPS_IO_OFF)
			else $error("disabled controller not switched off");
	end
endmodule : mps_io_unit

/* File: mps_power_ctrl.sv */
`timescale 1ns/10ps
`include "mps_regs.svh"
module mps_power_ctrl #(
	parameter int N_CORE = 4,
	parameter int N_SRAM = 4,
	parameter int N_IO   = 4
) (
	input  logic                    sys_clk,
	input  logic                    srst,
	input  logic [7:0]              reg_addr,
	input  logic [31:0]             reg_wdata,
	input  logic                    reg_wr,
	input  logic                    reg_rd,
	output logic [31:0]             reg_rdata,
	input  logic                    cpu_deep_sleep,
	input  logic [N_CORE-1:0]       core_pend,
	output logic [N_CORE-1:0]       core_grant,
	input  logic [N_SRAM-1:0]       sram_pend,
	output logic [N_SRAM-1:0]       sram_grant,
	output logic [2*N_CORE-1:0]     core_mem_state,
	output logic [2*N_SRAM-1:0]     sram_mem_state,
	input  logic [N_IO-1:0]         io_idle_req,
	input  logic [N_IO-1:0]         io_wake_req,
	output logic [2*N_IO-1:0]       io_state,
	output logic [N_IO-1:0]         io_power_on
);
	import mps_pkg::*;

	localparam int N_MEM = N_CORE + N_SRAM;

	// ************************************
	// Registers
	// ************************************
	logic [N_CORE-1:0] core_memory_power_enable_r;
	logic [N_CORE-1:0] core_memory_retention_config_r;
	logic [N_SRAM-1:0] shared_sram_power_enable_r;
	logic [N_SRAM-1:0] shared_sram_retention_config_r;
	logic [N_IO-1:0]   io_dev_en_r;
	logic [N_IO-1:0]   io_if_act_r;
	logic [N_IO-1:0]   io_auto_off_r;
	logic [N_IO-1:0]   io_auto_on_r;
	mps_hyst_t         hyst_r;
	logic [31:0]       rdata_r;
	logic [31:0]       rdata_nxt;
	logic [31:0]       mem_state_word;
	logic [31:0]       io_state_word;
	logic              wr_core_en;
	logic              wr_io_en;
	logic [N_IO-1:0]   io_en_set_r;

	assign wr_core_en = reg_wr && reg_addr == `MPS_CORE_EN_OFS;
	assign wr_io_en   = reg_wr && reg_addr == `MPS_IO_EN_OFS;

	// Core memories: nonvolatile, tightly coupled and cache.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			core_memory_power_enable_r     <= N_CORE'(`MPS_EN_RST);
			core_memory_retention_config_r <= N_CORE'(`MPS_RET_RST);
		end else if (reg_wr) begin
			if (reg_addr == `MPS_CORE_EN_OFS)
				core_memory_power_enable_r <= reg_wdata[N_CORE-1:0];
			if (reg_addr == `MPS_CORE_RET_OFS)
				core_memory_retention_config_r <= reg_wdata[N_CORE-1:0];
		end
	end

	// Shared SRAM banks.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			shared_sram_power_enable_r     <= N_SRAM'(`MPS_EN_RST);
			shared_sram_retention_config_r <= N_SRAM'(`MPS_RET_RST);
		end else if (reg_wr) begin
			if (reg_addr == `MPS_SRAM_EN_OFS)
				shared_sram_power_enable_r <= reg_wdata[N_SRAM-1:0];
			if (reg_addr == `MPS_SRAM_RET_OFS)
				shared_sram_retention_config_r <= reg_wdata[N_SRAM-1:0];
		end
	end

	// I/O controller settings.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			io_dev_en_r   <= '0;
			io_if_act_r   <= '0;
			io_auto_off_r <= '0;
			io_auto_on_r  <= '0;
		end else if (reg_wr) begin
			if (reg_addr == `MPS_IO_EN_OFS)
				io_dev_en_r <= reg_wdata[N_IO-1:0];
			if (reg_addr == `MPS_IO_ACT_OFS)
				io_if_act_r <= reg_wdata[N_IO-1:0];
			if (reg_addr == `MPS_IO_AUTO_OFS) begin
				io_auto_off_r <= reg_wdata[`MPS_AUTO_OFF_LSB +: N_IO];
				io_auto_on_r  <= reg_wdata[`MPS_AUTO_ON_LSB +: N_IO];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst)
			hyst_r <= `MPS_HYST_RST;
		else if (reg_wr && reg_addr == `MPS_HYST_OFS)
			hyst_r <= reg_wdata[15:0];
	end

	// Software power-on pulse, delayed so that it lines up with the new device enable bits.
	always_ff @(posedge sys_clk) begin
		if (srst)
			io_en_set_r <= '0;
		else
			io_en_set_r <= wr_io_en ? reg_wdata[N_IO-1:0] : '0;
	end

	// ************************************
	// Read path
	// ************************************
	always_comb begin
		rdata_nxt = '0;
		case (reg_addr)
			`MPS_CORE_EN_OFS:   rdata_nxt[N_CORE-1:0] = core_memory_power_enable_r;
			`MPS_CORE_RET_OFS:  rdata_nxt[N_CORE-1:0] = core_memory_retention_config_r;
			`MPS_SRAM_EN_OFS:   rdata_nxt[N_SRAM-1:0] = shared_sram_power_enable_r;
			`MPS_SRAM_RET_OFS:  rdata_nxt[N_SRAM-1:0] = shared_sram_retention_config_r;
			`MPS_IO_EN_OFS:     rdata_nxt[N_IO-1:0] = io_dev_en_r;
			`MPS_IO_ACT_OFS:    rdata_nxt[N_IO-1:0] = io_if_act_r;
			`MPS_IO_AUTO_OFS: begin
				rdata_nxt[`MPS_AUTO_OFF_LSB +: N_IO] = io_auto_off_r;
				rdata_nxt[`MPS_AUTO_ON_LSB +: N_IO]  = io_auto_on_r;
			end
			`MPS_HYST_OFS:      rdata_nxt[15:0] = hyst_r;
			`MPS_MEM_STATE_OFS: rdata_nxt = mem_state_word;
			`MPS_IO_STATE_OFS:  rdata_nxt = io_state_word;
			default:            rdata_nxt = '0;
		endcase
	end

	// Read data is held for one cycle only, then returns to zero.
	always_ff @(posedge sys_clk) begin
		if (srst)
			rdata_r <= '0;
		else if (reg_rd)
			rdata_r <= rdata_nxt;
		else
			rdata_r <= '0;
	end

	assign reg_rdata = rdata_r;

	// ************************************
	// Memory power units
	// ************************************
	logic [N_MEM-1:0] mem_pend;
	logic [N_MEM-1:0] mem_grant;
	logic [N_MEM-1:0] mem_en;
	logic [N_MEM-1:0] mem_ret;
	mps_mem_state_e   mem_state [N_MEM];

	assign mem_pend   = {sram_pend, core_pend};
	assign mem_en     = {shared_sram_power_enable_r, core_memory_power_enable_r};
	assign mem_ret    = {shared_sram_retention_config_r, core_memory_retention_config_r};
	assign core_grant = mem_grant[N_CORE-1:0];
	assign sram_grant = mem_grant[N_MEM-1:N_CORE];

	always_comb begin
		mem_state_word = '0;
		for (int k = 0; k < N_MEM; k++)
			mem_state_word[2*k +: 2] = mem_state[k];
	end

	assign core_mem_state = mem_state_word[2*N_CORE-1:0];
	assign sram_mem_state = mem_state_word[2*N_MEM-1:2*N_CORE];

	for (genvar m = 0; m < N_MEM; m++) begin : g_mem
		mps_mem_unit #(
			.WAKE_W     (4)
		) u_mem (
			.sys_clk    (sys_clk),
			.srst       (srst),
			.deep_sleep (cpu_deep_sleep),
			.pend       (mem_pend[m]),
			.pwr_en     (mem_en[m]),
			.ret_en     (mem_ret[m]),
			.hyst_load  (hyst_r),
			.state      (mem_state[m]),
			.grant      (mem_grant[m])
		);

		awake_cpu_a: assert property (@(posedge sys_clk) disable iff (srst)
			(!cpu_deep_sleep && mem_state[m] == MPS_MEM_ACTIVE) |=> mem_state[m] == MPS_MEM_ACTIVE)
			else $error("memory dropped power while cpu awake");

		pend_wake_a: assert property (@(posedge sys_clk) disable iff (srst)
			(mem_pend[m] && mem_state[m] == MPS_MEM_RET)
			|=> mem_state[m] == MPS_MEM_WAKE [*2] ##1 mem_state[m] == MPS_MEM_ACTIVE)
			else $error("retained memory not woken on time");

		off_wake_a: assert property (@(posedge sys_clk) disable iff (srst)
			(mem_pend[m] && mem_state[m] == MPS_MEM_OFF)
			|=> mem_state[m] == MPS_MEM_WAKE [*5] ##1 mem_state[m] == MPS_MEM_WAKE [*5]
			##1 mem_state[m] == MPS_MEM_ACTIVE)
			else $error("powered-down memory not woken on time");

		pend_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
			mem_grant[m] == (mem_pend[m] && mem_state[m] == MPS_MEM_ACTIVE))
			else $error("grant does not match active state");

		ret_entry_a: assert property (@(posedge sys_clk) disable iff (srst)
			(mem_state[m] == MPS_MEM_RET && $past(mem_state[m]) == MPS_MEM_ACTIVE)
			|-> ($past(mem_en[m]) && $past(mem_ret[m])))
			else $error("retention entered without enable and retention set");

		dis_off_a: assert property (@(posedge sys_clk) disable iff (srst)
			(mem_state[m] == MPS_MEM_ACTIVE && !mem_en[m] && mem_ret[m]) |=> mem_state[m] != MPS_MEM_RET)
			else $error("disabled memory entered retention");

		en_off_a: assert property (@(posedge sys_clk) disable iff (srst)
			(mem_state[m] == MPS_MEM_OFF && $past(mem_state[m]) == MPS_MEM_ACTIVE)
			|-> !($past(mem_en[m]) && $past(mem_ret[m])))
			else $error("memory powered down though retention requested");

		ret_stay_a: assert property (@(posedge sys_clk) disable iff (srst)
			(mem_state[m] == MPS_MEM_RET && cpu_deep_sleep && !mem_pend[m]) |=> mem_state[m] == MPS_MEM_RET)
			else $error("retained memory left retention without cause");

		off_stay_a: assert property (@(posedge sys_clk) disable iff (srst)
			(mem_state[m] == MPS_MEM_OFF && cpu_deep_sleep && !mem_pend[m]) |=> mem_state[m] == MPS_MEM_OFF)
			else $error("powered-down memory left off without cause");

		cpu_wake_a: assert property (@(posedge sys_clk) disable iff (srst)
			(!cpu_deep_sleep && mem_state[m] inside {MPS_MEM_RET, MPS_MEM_OFF}) |=> mem_state[m] == MPS_MEM_WAKE)
			else $error("memory not woken when cpu left deep sleep");

		wake_end_a: assert property (@(posedge sys_clk) disable iff (srst)
			mem_state[m] == MPS_MEM_WAKE |=> mem_state[m] inside {MPS_MEM_WAKE, MPS_MEM_ACTIVE})
			else $error("waking memory fell back to low power");
	end

	// ************************************
	// I/O controller power
	// ************************************
	mps_io_if #(.N_IO(N_IO)) io_bus ();

	assign io_bus.dev_en   = io_dev_en_r;
	assign io_bus.en_set   = io_en_set_r;
	assign io_bus.if_act   = io_if_act_r;
	assign io_bus.auto_off = io_auto_off_r;
	assign io_bus.auto_on  = io_auto_on_r;
	assign io_bus.idle_req = io_idle_req;
	assign io_bus.wake_req = io_wake_req;

	mps_io_unit #(
		.N_IO    (N_IO)
	) u_io (
		.sys_clk (sys_clk),
		.srst    (srst),
		.io      (io_bus)
	);

	always_comb begin
		io_state_word = '0;
		for (int k = 0; k < N_IO; k++)
			io_state_word[2*k +: 2] = io_bus.state[k];
	end

	assign io_state = io_state_word[2*N_IO-1:0];

	for (genvar j = 0; j < N_IO; j++) begin : g_io_chk
		assign io_power_on[j] = io_bus.state[j] != MPS_IO_OFF;

		auto_off_a: assert property (@(posedge sys_clk) disable iff (srst)
			(io_bus.state[j] == MPS_IO_SLEEP && io_dev_en_r[j] && !io_if_act_r[j]
			 && io_auto_off_r[j] && io_idle_req[j]) |=> io_bus.state[j] == MPS_IO_OFF)
			else $error("idle controller not switched off automatically");

		no_auto_off_a: assert property (@(posedge sys_clk) disable iff (srst)
			(io_bus.state[j] == MPS_IO_SLEEP && io_dev_en_r[j] && !io_auto_off_r[j]) |=> io_bus.state[j] != MPS_IO_OFF)
			else $error("controller switched off without request");

		idle_sleep_a: assert property (@(posedge sys_clk) disable iff (srst)
			(io_bus.state[j] == MPS_IO_ACTIVE && io_dev_en_r[j] && !io_if_act_r[j]) |=> io_bus.state[j] == MPS_IO_SLEEP)
			else $error("inactive interface not moved to sleep");

		auto_on_a: assert property (@(posedge sys_clk) disable iff (srst)
			(io_bus.state[j] == MPS_IO_OFF && io_dev_en_r[j] && io_auto_on_r[j] && io_wake_req[j])
			|=> io_bus.state[j] == MPS_IO_SLEEP)
			else $error("controller not powered on automatically");

		sw_on_a: assert property (@(posedge sys_clk) disable iff (srst)
			(io_bus.state[j] == MPS_IO_OFF && !io_en_set_r[j]
			 && !(io_auto_on_r[j] && io_wake_req[j])) |=> io_bus.state[j] == MPS_IO_OFF)
			else $error("controller powered on without cause");

		sw_on_sleep_a: assert property (@(posedge sys_clk) disable iff (srst)
			(io_bus.state[j] == MPS_IO_OFF && io_dev_en_r[j] && io_en_set_r[j]) |=> io_bus.state[j] == MPS_IO_SLEEP)
			else $error("enabled controller not moved to sleep");

		sleep_act_a: assert property (@(posedge sys_clk) disable iff (srst)
			(io_bus.state[j] == MPS_IO_SLEEP && io_dev_en_r[j] && io_if_act_r[j]) |=> io_bus.state[j] == MPS_IO_ACTIVE)
			else $error("activated interface not moved to active");

		sleep_stay_a: assert property (@(posedge sys_clk) disable iff (srst)
			(io_bus.state[j] == MPS_IO_SLEEP && io_dev_en_r[j] && !io_if_act_r[j]
			 && !(io_auto_off_r[j] && io_idle_req[j])) |=> io_bus.state[j] == MPS_IO_SLEEP)
			else $error("idle controller left sleep without cause");

		active_stay_a: assert property (@(posedge sys_clk) disable iff (srst)
			(io_bus.state[j] == MPS_IO_ACTIVE && io_dev_en_r[j] && io_if_act_r[j]) |=> io_bus.state[j] == MPS_IO_ACTIVE)
			else $error("active controller left active without cause");
	end

	// ************************************
	// Register bus checks
	// ************************************
	rd_pulse_a: assert property (@(posedge sys_clk) disable iff (srst)
		!reg_rd |=> reg_rdata == '0)
		else $error("read data present without a read");

	hyst_wr_a: assert property (@(posedge sys_clk) disable iff (srst)
		(reg_wr && reg_addr == `MPS_HYST_OFS) |=> hyst_r == $past(reg_wdata[15:0]))
		else $error("hysteresis reload not written");

	en_wr_a: assert property (@(posedge sys_clk) disable iff (srst)
		wr_core_en |=> core_memory_power_enable_r == $past(reg_wdata[N_CORE-1:0]))
		else $error("core memory enable not written");

	sram_en_wr_a: assert property (@(posedge sys_clk) disable iff (srst)
		(reg_wr && reg_addr == `MPS_SRAM_EN_OFS) |=> shared_sram_power_enable_r == $past(reg_wdata[N_SRAM-1:0]))
		else $error("shared sram enable not written");

	ret_wr_a: assert property (@(posedge sys_clk) disable iff (srst)
		(reg_wr && reg_addr == `MPS_CORE_RET_OFS) |=> core_memory_retention_config_r == $past(reg_wdata[N_CORE-1:0]))
		else $error("core memory retention not written");

	sram_ret_wr_a: assert property (@(posedge sys_clk) disable iff (srst)
		(reg_wr && reg_addr == `MPS_SRAM_RET_OFS) |=> shared_sram_retention_config_r == $past(reg_wdata[N_SRAM-1:0]))
		else $error("shared sram retention not written");

	io_en_wr_a: assert property (@(posedge sys_clk) disable iff (srst)
		wr_io_en |=> io_dev_en_r == $past(reg_wdata[N_IO-1:0]))
		else $error("device enable not written");

	rd_hyst_a: assert property (@(posedge sys_clk) disable iff (srst)
		(reg_rd && reg_addr == `MPS_HYST_OFS) |=> reg_rdata == {16'h0000, $past(hyst_r)})
		else $error("hysteresis reload read back wrong");

endmodule : mps_power_ctrl

/* File: mps_mem_master_model.sv */
`timescale 1ns/10ps
// ************************************
// Bus master model
// ************************************
module mps_mem_master_model #(
	parameter int N = 8
) (
	input  logic         sys_clk,
	input  logic         srst,
	input  logic [N-1:0] req,
	input  logic [N-1:0] grant,
	output logic [N-1:0] pend
);
	// A request stays pending until its grant is seen at an edge, so a slow wake is never cut short.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pend <= '0;
		end else begin
			pend <= (pend & ~grant) | req;
		end
	end
endmodule : mps_mem_master_model

/* File: test_memory_io_power_state_ctrl.sv */
`timescale 1ns/10ps
module test_memory_io_power_state_ctrl;
	import mps_pkg::*;
	// ************************************
	// Signals
	// ************************************
	logic        sys_clk;
	logic        srst;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        cpu_deep_sleep;
	logic [3:0]  io_idle_req;
	logic [3:0]  io_wake_req;
	logic [7:0]  io_state;
	logic [3:0]  io_power_on;
	logic [7:0]  req;
	wire  [7:0]  pend;
	wire  [7:0]  grant;
	wire  [15:0] mem_st;
	logic [31:0] rd;
	int          failures;
	int          n_tests;
	int          cycles;
	logic [7:0]  zero_regs [7] = '{8'h04, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24};

	mps_power_ctrl dut (
		.sys_clk        (sys_clk),
		.srst           (srst),
		.reg_addr       (reg_addr),
		.reg_wdata      (reg_wdata),
		.reg_wr         (reg_wr),
		.reg_rd         (reg_rd),
		.reg_rdata      (reg_rdata),
		.cpu_deep_sleep (cpu_deep_sleep),
		.core_pend      (pend[3:0]),
		.core_grant     (grant[3:0]),
		.sram_pend      (pend[7:4]),
		.sram_grant     (grant[7:4]),
		.core_mem_state (mem_st[7:0]),
		.sram_mem_state (mem_st[15:8]),
		.io_idle_req    (io_idle_req),
		.io_wake_req    (io_wake_req),
		.io_state       (io_state),
		.io_power_on    (io_power_on)
	);

	mps_mem_master_model #(.N(8)) master (
		.sys_clk (sys_clk),
		.srst    (srst),
		.req     (req),
		.grant   (grant),
		.pend    (pend)
	);

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// ************************************
	// Tasks
	// ************************************
	task automatic fail(input string msg);
		failures++;
		$display("CHECK FAILED at %0t: %s", $time, msg);
	endtask : fail

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail($sformatf("register read %h, expected %h", got, exp));
		end
	endtask : chk_reg

	task automatic chk_state(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail($sformatf("state %h, expected %h", got, exp));
		end
	endtask : chk_state

	task automatic chk_lat(input int got, input int exp);
		n_tests++;
		if (got != exp) begin
			fail($sformatf("grant after %0d cycles, expected %0d", got, exp));
		end
	endtask : chk_lat

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : wait_cyc

	task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
		@(posedge sys_clk);
		reg_addr  <= addr;
		reg_wdata <= data;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] addr, output logic [31:0] data);
		@(posedge sys_clk);
		reg_addr <= addr;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd   <= 1'b0;
		#1;
		data = reg_rdata;
	endtask : reg_read

	// Issues one transfer and counts the edges from the raise of pend to the grant.
	task automatic mem_req(input int idx, input int exp);
		int n;
		n = 0;
		@(posedge sys_clk);
		req[idx] <= 1'b1;
		@(posedge sys_clk);
		req <= '0;
		#1;
		while (grant[idx] !== 1'b1 && n < 50) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk_lat(n, exp);
		wait_cyc(2);
	endtask : mem_req

	task automatic test_done;
		$display("Comparisons: %0d, mismatches: %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : test_done

	// ************************************
	// Monitors
	// ************************************
	// A grant must appear exactly while the target is active and a transfer waits.
	always @(posedge sys_clk) begin
		if (!srst) begin
			for (int k = 0; k < 8; k++) begin
				if (grant[k] !== (pend[k] && mem_st[2*k+:2] === 2'b00)) begin
					fail($sformatf("grant %0d does not follow target state", k));
				end
			end
		end
	end

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail("run did not finish in time");
			test_done();
		end
	end

	// ************************************
	// Main sequence
	// ************************************
	initial begin
		srst           = 1'b1;
		reg_addr       = 8'h00;
		reg_wdata      = 32'h0000_0000;
		reg_wr         = 1'b0;
		reg_rd         = 1'b0;
		cpu_deep_sleep = 1'b0;
		io_idle_req    = 4'h0;
		io_wake_req    = 4'h0;
		req            = 8'h00;
		failures       = 0;
		n_tests        = 0;
		cycles         = 0;
		repeat (16) @(posedge sys_clk);
		srst <= 1'b0;
		foreach (zero_regs[i]) begin
			reg_read(zero_regs[i], rd);
			chk_reg(rd, 32'h0000_0000);
		end
		reg_read(8'h1C, rd);
		chk_reg(rd, 32'h0000_0040);
		reg_read(8'h00, rd);
		chk_reg(rd & 32'h0000_000F, 32'h0000_000F);
		reg_read(8'h30, rd);
		chk_reg(rd, 32'h0000_0000);
		reg_write(8'h00, 32'h0000_0007);
		reg_write(8'h04, 32'h0000_000D);
		reg_write(8'h0C, 32'h0000_0003);
		reg_write(8'h08, 32'h0000_000F);
		reg_write(8'h1C, 32'h0000_0004);
		reg_write(8'h20, 32'h0000_FFFF);
		reg_read(8'h00, rd);
		chk_reg(rd, 32'h0000_0007);
		reg_read(8'h08, rd);
		chk_reg(rd, 32'h0000_000F);
		reg_read(8'h1C, rd);
		chk_reg(rd, 32'h0000_0004);
		wait_cyc(20);
		chk_state(mem_st, 16'h0000);
		reg_read(8'h20, rd);
		chk_reg(rd, 32'h0000_0000);
		mem_req(2, 0);
		@(posedge sys_clk);
		cpu_deep_sleep <= 1'b1;
		wait_cyc(3);
		chk_state(mem_st, 16'h0000);
		wait_cyc(10);
		chk_state(mem_st, 16'hA599);
		reg_read(8'h20, rd);
		chk_reg(rd, 32'h0000_A599);
		mem_req(0, 3);
		mem_req(1, 11);
		mem_req(3, 11);
		mem_req(4, 3);
		wait_cyc(20);
		chk_state(mem_st, 16'hA599);
		reg_write(8'h10, 32'h0000_0003);
		wait_cyc(3);
		chk_state({8'h00, io_state}, 16'h0005);
		chk_state({12'h000, io_power_on}, 16'h0003);
		reg_read(8'h24, rd);
		chk_reg(rd, 32'h0000_0005);
		reg_write(8'h14, 32'h0000_0001);
		wait_cyc(3);
		chk_state({8'h00, io_state}, 16'h0007);
		reg_write(8'h14, 32'h0000_0000);
		wait_cyc(3);
		chk_state({8'h00, io_state}, 16'h0005);
		reg_write(8'h18, 32'h0002_0002);
		@(posedge sys_clk);
		io_idle_req <= 4'h2;
		wait_cyc(3);
		chk_state({8'h00, io_state}, 16'h0001);
		@(posedge sys_clk);
		io_idle_req <= 4'h0;
		io_wake_req <= 4'h2;
		wait_cyc(3);
		chk_state({8'h00, io_state}, 16'h0005);
		reg_write(8'h10, 32'h0000_0000);
		wait_cyc(3);
		chk_state({8'h00, io_state}, 16'h0000);
		chk_state({12'h000, io_power_on}, 16'h0000);
		@(posedge sys_clk);
		cpu_deep_sleep <= 1'b0;
		wait_cyc(11);
		chk_state(mem_st, 16'h0000);
		test_done();
	end
endmodule : test_memory_io_power_state_ctrl
